/* hw/cxd_consts.vh */
// Shared constants of the execution datapath
`ifndef CXD_CONSTS_VH
`define CXD_CONSTS_VH
// Register sets: nine thread contexts plus one shadow set
`define CXD_GPR_WORDS   320
`define CXD_SHADOW_SET  4'h9
// Divide timing floor in cycles
`define CXD_DIV_MIN_CYC 6'h06
`define CXD_DIV_BITS    6'h20
// Integer operation codes
`define CXD_OP_ADD   5'h00
`define CXD_OP_SUB   5'h01
`define CXD_OP_AND   5'h02
`define CXD_OP_OR    5'h03
`define CXD_OP_XOR   5'h04
`define CXD_OP_NOR   5'h05
`define CXD_OP_SLL   5'h06
`define CXD_OP_SRL   5'h07
`define CXD_OP_SRA   5'h08
`define CXD_OP_CLZ   5'h09
`define CXD_OP_CLO   5'h0A
`define CXD_OP_LOAD  5'h0B
`define CXD_OP_STORE 5'h0C
`define CXD_OP_BEQ   5'h0D
`define CXD_OP_BNE   5'h0E
`define CXD_OP_MULT  5'h0F
`define CXD_OP_FUSED_MUL_ADD  5'h10
`define CXD_OP_DIV   5'h11
`define CXD_OP_DIVU  5'h12
`define CXD_OP_MFHI  5'h13
`define CXD_OP_MFLO  5'h14
// Memory access sizes
`define CXD_SZ_BYTE  2'h0
`define CXD_SZ_HALF  2'h1
// Float operation codes
`define CXD_FOP_ADD  3'h0
`define CXD_FOP_MUL  3'h1
`define CXD_FOP_FUSED_MUL_ADD 3'h2
`define CXD_FOP_FUSED_MUL_SUB 3'h3
`define CXD_FOP_MOVD 3'h4
`define CXD_FOP_NEGD 3'h5
`define CXD_FOP_ABSD 3'h6
// Single precision encoding
`define CXD_FP_BIAS  10'h07F
`define CXD_FP_EMAX  10'sh0FF
`define CXD_FP_QNAN  32'h7FC00000
`endif

/* hw/cxd_exec_datapath.v */
// Execution datapath: integer unit, multiply/divide unit, float unit
`timescale 1ns/10ps
`include "cxd_consts.vh"
module cxd_exec_datapath
#(
  parameter FP_HALF_RATE = 0
)
(
  input  wire        i_clk,
  input  wire        i_sys_rst,
  input  wire        i_ce,
  input  wire        i_issue_valid,
  input  wire [3:0]  i_thread,
  input  wire        i_use_shadow,
  input  wire [4:0]  i_op,
  input  wire [4:0]  i_rs,
  input  wire [4:0]  i_rt,
  input  wire [4:0]  i_rd,
  input  wire [15:0] i_imm,
  input  wire        i_use_imm,
  input  wire [1:0]  i_mem_size,
  input  wire        i_load_signed,
  input  wire        i_pred_taken,
  input  wire        i_load_valid,
  input  wire [31:0] i_load_data,
  input  wire        i_fp_valid,
  input  wire [2:0]  i_fp_op,
  input  wire [4:0]  i_fs,
  input  wire [4:0]  i_ft,
  input  wire [4:0]  i_fd,
  input  wire        i_fp_flush,
  input  wire        i_fp_load_valid,
  input  wire [4:0]  i_fp_load_idx,
  input  wire [63:0] i_fp_load_data,
  input  wire        i_fp_store_req,
  input  wire [4:0]  i_fp_store_idx,
  output reg         o_issue_ready,
  output reg         o_result_valid,
  output reg  [31:0] o_result,
  output reg         o_mem_re,
  output reg         o_mem_we,
  output reg  [31:0] o_mem_addr,
  output reg  [3:0]  o_mem_be,
  output reg  [31:0] o_mem_wdata,
  output reg         o_branch_valid,
  output reg         o_branch_taken,
  output reg         o_mispredict,
  output reg         o_mdu_busy,
  output reg  [31:0] o_result_high,
  output reg  [31:0] o_result_low,
  output reg         o_fp_ready,
  output reg         o_fp_result_valid,
  output reg  [63:0] o_fp_result,
  output reg         o_fp_tiny,
  output reg         o_fp_unimpl,
  output reg         o_fp_store_valid,
  output reg  [63:0] o_fp_store_data
);

  localparam DIV_IDLE = 1'b0;
  localparam DIV_RUN  = 1'b1;

  // Count of leading bits equal to the bit value given in one
  function [5:0] cxd_lead_count;
    input [31:0] v;
    input        one;
    integer      i;
    reg          done;
    begin
      cxd_lead_count = 6'h00;
      done = 1'b0;
      for (i = 31; i >= 0; i = i - 1)
        if (!done)
        begin
          if (v[i] == one)
            cxd_lead_count = cxd_lead_count + 6'h01;
          else
            done = 1'b1;
        end
    end
  endfunction

  // Round to nearest even and pack; bit 32 flags a flushed tiny result
  function [32:0] cxd_fp_pack;
    input              sg;
    input signed [9:0] e;
    input [27:0]       s;
    reg [24:0]         m;
    reg signed [9:0]   ee;
    begin
      m = {1'b0, s[26:3]} + {24'h000000, s[2] & (s[3] | s[1] | s[0])};
      ee = e;
      if (m[24])
      begin
        m = m >> 1;
        ee = ee + 10'sh001;
      end
      if (ee >= `CXD_FP_EMAX)
        cxd_fp_pack = {1'b0, sg, 8'hFF, 23'h000000};
      else if (ee <= 10'sh000)
        cxd_fp_pack = {1'b1, sg, 31'h00000000};
      else
        cxd_fp_pack = {1'b0, sg, ee[7:0], m[22:0]};
    end
  endfunction

  // Single precision multiply, rounded on its own
  function [32:0] cxd_fp_mul;
    input [31:0]     a;
    input [31:0]     b;
    reg [47:0]       p;
    reg signed [9:0] e;
    reg [27:0]       s;
    reg              sg;
    begin
      sg = a[31] ^ b[31];
      p = {1'b1, a[22:0]} * {1'b1, b[22:0]};
      e = {2'h0, a[30:23]} + {2'h0, b[30:23]} - `CXD_FP_BIAS;
      s = {1'b0, p[46:21], |p[20:0]};
      if (p[47])
      begin
        e = e + 10'sh001;
        s = {1'b0, p[47:22], |p[21:0]};
      end
      if (a[30:23] == 8'hFF || b[30:23] == 8'hFF)
        cxd_fp_mul = ((a[30:23] == 8'hFF && a[22:0] != 23'h0) ||
                      (b[30:23] == 8'hFF && b[22:0] != 23'h0) ||
                      a[30:23] == 8'h00 || b[30:23] == 8'h00) ?
                     {1'b0, `CXD_FP_QNAN} : {1'b0, sg, 8'hFF, 23'h000000};
      else if (a[30:23] == 8'h00 || b[30:23] == 8'h00)
        cxd_fp_mul = {1'b0, sg, 31'h00000000};
      else
        cxd_fp_mul = cxd_fp_pack(sg, e, s);
    end
  endfunction

  // Single precision add with sticky alignment
  function [32:0] cxd_fp_add;
    input [31:0]     a;
    input [31:0]     b;
    reg [31:0]       x;
    reg [31:0]       y;
    reg [7:0]        d;
    reg [27:0]       mx;
    reg [27:0]       my;
    reg [27:0]       s;
    reg signed [9:0] e;
    integer          i;
    begin
      x = (a[30:0] < b[30:0]) ? b : a;
      y = (a[30:0] < b[30:0]) ? a : b;
      d = x[30:23] - y[30:23];
      mx = {2'h1, x[22:0], 3'h0};
      my = (y[30:23] == 8'h00) ? 28'h0000000 : {2'h1, y[22:0], 3'h0};
      for (i = 0; i < 27; i = i + 1)
        if (i < d)
          my = {1'b0, my[27:2], my[1] | my[0]};
      s = (x[31] == y[31]) ? mx + my : mx - my;
      e = {2'h0, x[30:23]};
      if (s[27])
      begin
        s = {1'b0, s[27:2], s[1] | s[0]};
        e = e + 10'sh001;
      end
      for (i = 0; i < 26; i = i + 1)
        if (!s[26] && s != 28'h0000000)
        begin
          s = s << 1;
          e = e - 10'sh001;
        end
      if (x[30:23] == 8'hFF)
        cxd_fp_add = (x[22:0] != 23'h0 || (y[30:23] == 8'hFF && x[31] != y[31])) ?
                     {1'b0, `CXD_FP_QNAN} : {1'b0, x};
      else if (x[30:23] == 8'h00)
        cxd_fp_add = {1'b0, x[31] & y[31], 31'h00000000};
      else if (s == 28'h0000000)
        cxd_fp_add = 33'h000000000;
      else
        cxd_fp_add = cxd_fp_pack(x[31], e, s);
    end
  endfunction

  reg [31:0] gpr [0:`CXD_GPR_WORDS-1];
  reg [63:0] fregs [0:31];
  reg [8:0]  wb_addr_reg;
  reg        ld_wait_reg;
  reg [8:0]  ld_addr_reg;
  reg [1:0]  ld_off_reg;
  reg [1:0]  ld_size_reg;
  reg        ld_sgn_reg;
  reg        mf_wait_reg;
  reg        mf_hi_reg;
  reg [8:0]  mf_addr_reg;
  reg        m1_valid_reg;
  reg        m1_acc_reg;
  reg [63:0] m1_prod_reg;
  reg        div_state_reg;
  reg [5:0]  div_cyc_reg;
  reg [5:0]  div_steps_reg;
  reg [31:0] div_rem_reg;
  reg [31:0] div_q_reg;
  reg [31:0] div_dvs_reg;
  reg        div_qneg_reg;
  reg        div_rneg_reg;
  reg        fp_phase_reg;
  reg        fwb_valid_reg;
  reg [4:0]  fwb_idx_reg;
  reg [31:0] alu_res;
  reg [32:0] fp_res;

  // Register set of the issuing thread or the shadow set
  wire [3:0]  set_sel  = i_use_shadow ? `CXD_SHADOW_SET : i_thread;
  wire [8:0]  rs_addr  = {set_sel, i_rs};
  wire [8:0]  rt_addr  = {set_sel, i_rt};
  wire [8:0]  rd_addr  = {set_sel, i_rd};
  // Two read ports with forwarding from the write-back stage
  wire [31:0] rs_val   = (i_rs == 5'h00) ? 32'h00000000 :
                         (o_result_valid && wb_addr_reg == rs_addr) ? o_result :
                         gpr[rs_addr];
  wire [31:0] rt_val   = (i_rt == 5'h00) ? 32'h00000000 :
                         (o_result_valid && wb_addr_reg == rt_addr) ? o_result :
                         gpr[rt_addr];
  wire [31:0] sext_imm = {{16{i_imm[15]}}, i_imm};
  wire [31:0] opb      = i_use_imm ? sext_imm : rt_val;
  wire        issue    = i_issue_valid & o_issue_ready;
  wire        is_alu   = i_op <= `CXD_OP_CLO;
  wire        is_mf    = (i_op == `CXD_OP_MFHI) | (i_op == `CXD_OP_MFLO);
  wire        is_div   = (i_op == `CXD_OP_DIV) | (i_op == `CXD_OP_DIVU);
  wire        mul_go   = issue & ((i_op == `CXD_OP_MULT) | (i_op == `CXD_OP_FUSED_MUL_ADD));
  // Dedicated address adder, apart from the main ALU
  wire [31:0] agen     = rs_val + sext_imm;
  wire        hilo_busy = m1_valid_reg | (div_state_reg == DIV_RUN);
  wire        ld_wait_next = ld_wait_reg ? ~i_load_valid : (issue & (i_op == `CXD_OP_LOAD));
  wire        mf_wait_next = mf_wait_reg ? hilo_busy : (issue & is_mf & hilo_busy);
  wire        mf_go    = (mf_wait_reg | (issue & is_mf)) & ~hilo_busy;
  wire        mf_sel_hi = mf_wait_reg ? mf_hi_reg : (i_op == `CXD_OP_MFHI);
  wire [8:0]  mf_dst   = mf_wait_reg ? mf_addr_reg : rd_addr;
  wire        br_taken = (rs_val == rt_val) ^ (i_op == `CXD_OP_BNE);
  // Load data shifted down to its byte lane
  wire [31:0] ld_sh    = i_load_data >> {ld_off_reg, 3'h0};
  wire [31:0] ld_al    = (ld_size_reg == `CXD_SZ_BYTE) ? {{24{ld_sgn_reg & ld_sh[7]}}, ld_sh[7:0]} :
                         (ld_size_reg == `CXD_SZ_HALF) ? {{16{ld_sgn_reg & ld_sh[15]}}, ld_sh[15:0]} :
                         ld_sh;
  // Divide operands and one restoring step
  wire        div_sa   = (i_op == `CXD_OP_DIV) & rs_val[31];
  wire        div_sb   = (i_op == `CXD_OP_DIV) & rt_val[31];
  wire [31:0] div_absa = div_sa ? ~rs_val + 32'h00000001 : rs_val;
  wire [5:0]  div_lz   = cxd_lead_count(div_absa, 1'b0);
  wire [5:0]  div_n    = `CXD_DIV_BITS - div_lz;
  wire [32:0] div_r2   = {div_rem_reg, div_q_reg[31]};
  wire        div_ge   = div_r2 >= {1'b0, div_dvs_reg};
  wire        div_do   = div_steps_reg != 6'h00;
  wire [31:0] div_rem_n = ~div_do ? div_rem_reg :
                          div_ge ? div_r2[31:0] - div_dvs_reg : div_r2[31:0];
  wire [31:0] div_q_n  = div_do ? {div_q_reg[30:0], div_ge} : div_q_reg;
  wire        div_done = (div_state_reg == DIV_RUN) && (div_cyc_reg == 6'h01);
  wire signed [63:0] mul_full = $signed(rs_val) * $signed(rt_val);
  // Float unit enable and operand forwarding
  wire        fp_en    = (FP_HALF_RATE == 0) | fp_phase_reg;
  wire        fp_issue = i_fp_valid & o_fp_ready;
  wire [63:0] fa = (fwb_valid_reg && fwb_idx_reg == i_fs) ? o_fp_result : fregs[i_fs];
  wire [63:0] fb = (fwb_valid_reg && fwb_idx_reg == i_ft) ? o_fp_result : fregs[i_ft];
  wire [63:0] fc = (fwb_valid_reg && fwb_idx_reg == i_fd) ? o_fp_result : fregs[i_fd];
  wire [63:0] fst = (fwb_valid_reg && fwb_idx_reg == i_fp_store_idx) ? o_fp_result :
                    fregs[i_fp_store_idx];
  wire [32:0] fprod = cxd_fp_mul(fa[31:0], fb[31:0]);

  // Single-cycle ALU, shifter and leading bit counts
  always @*
  begin
    alu_res = 32'h00000000;
    case (i_op)
      `CXD_OP_ADD: alu_res = rs_val + opb;
      `CXD_OP_SUB: alu_res = rs_val - opb;
      `CXD_OP_AND: alu_res = rs_val & opb;
      `CXD_OP_OR:  alu_res = rs_val | opb;
      `CXD_OP_XOR: alu_res = rs_val ^ opb;
      `CXD_OP_NOR: alu_res = ~(rs_val | opb);
      `CXD_OP_SLL: alu_res = rt_val << i_imm[4:0];
      `CXD_OP_SRL: alu_res = rt_val >> i_imm[4:0];
      `CXD_OP_SRA: alu_res = $signed(rt_val) >>> i_imm[4:0];
      `CXD_OP_CLZ: alu_res = {26'h0000000, cxd_lead_count(rs_val, 1'b0)};
      `CXD_OP_CLO: alu_res = {26'h0000000, cxd_lead_count(rs_val, 1'b1)};
      default:     alu_res = 32'h00000000;
    endcase
  end

  // Float operations; fused forms add the already rounded product
  always @*
  begin
    fp_res = {1'b0, fa[31:0]};
    case (i_fp_op)
      `CXD_FOP_ADD:  fp_res = cxd_fp_add(fa[31:0], fb[31:0]);
      `CXD_FOP_MUL:  fp_res = fprod;
      `CXD_FOP_FUSED_MUL_ADD: fp_res = cxd_fp_add(fprod[31:0], fc[31:0]) | {fprod[32], 32'h0};
      `CXD_FOP_FUSED_MUL_SUB: fp_res = cxd_fp_add(fprod[31:0], {~fc[31], fc[30:0]}) | {fprod[32], 32'h0};
      default:       fp_res = {1'b0, fa[31:0]};
    endcase
  end

  // Integer pipeline, memory access, branch check and issue control
  always @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_issue_ready <= 1'b1;
      o_result_valid <= 1'b0;
      o_result <= 32'h00000000;
      wb_addr_reg <= 9'h000;
      o_mem_re <= 1'b0;
      o_mem_we <= 1'b0;
      o_mem_addr <= 32'h00000000;
      o_mem_be <= 4'h0;
      o_mem_wdata <= 32'h00000000;
      o_branch_valid <= 1'b0;
      o_branch_taken <= 1'b0;
      o_mispredict <= 1'b0;
      ld_wait_reg <= 1'b0;
      ld_addr_reg <= 9'h000;
      ld_off_reg <= 2'h0;
      ld_size_reg <= 2'h0;
      ld_sgn_reg <= 1'b0;
      mf_wait_reg <= 1'b0;
      mf_hi_reg <= 1'b0;
      mf_addr_reg <= 9'h000;
    end
    else if (i_ce)
    begin
      if (o_result_valid)
        gpr[wb_addr_reg] <= o_result;
      o_result_valid <= 1'b0;
      o_mem_re <= 1'b0;
      o_mem_we <= 1'b0;
      o_branch_valid <= 1'b0;
      o_mispredict <= 1'b0;
      if (issue && is_alu && i_rd != 5'h00)
      begin
        o_result_valid <= 1'b1;
        o_result <= alu_res;
        wb_addr_reg <= rd_addr;
      end
      else if (ld_wait_reg && i_load_valid && ld_addr_reg[4:0] != 5'h00)
      begin
        o_result_valid <= 1'b1;
        o_result <= ld_al;
        wb_addr_reg <= ld_addr_reg;
      end
      else if (mf_go && mf_dst[4:0] != 5'h00)
      begin
        o_result_valid <= 1'b1;
        o_result <= mf_sel_hi ? o_result_high : o_result_low;
        wb_addr_reg <= mf_dst;
      end
      if (issue && (i_op == `CXD_OP_LOAD || i_op == `CXD_OP_STORE))
      begin
        o_mem_re <= i_op == `CXD_OP_LOAD;
        o_mem_we <= i_op == `CXD_OP_STORE;
        o_mem_addr <= agen;
        o_mem_wdata <= rt_val << {agen[1:0], 3'h0};
        o_mem_be <= (i_mem_size == `CXD_SZ_BYTE) ? 4'h1 << agen[1:0] :
                    (i_mem_size == `CXD_SZ_HALF) ? (agen[1] ? 4'hC : 4'h3) : 4'hF;
        ld_addr_reg <= rd_addr;
        ld_off_reg <= agen[1:0];
        ld_size_reg <= i_mem_size;
        ld_sgn_reg <= i_load_signed;
      end
      if (issue && (i_op == `CXD_OP_BEQ || i_op == `CXD_OP_BNE))
      begin
        o_branch_valid <= 1'b1;
        o_branch_taken <= br_taken;
        o_mispredict <= br_taken != i_pred_taken;
      end
      if (issue && is_mf)
      begin
        mf_hi_reg <= i_op == `CXD_OP_MFHI;
        mf_addr_reg <= rd_addr;
      end
      ld_wait_reg <= ld_wait_next;
      mf_wait_reg <= mf_wait_next;
      o_issue_ready <= ~(ld_wait_next | mf_wait_next);
    end
  end

  // Multiply pipeline and divide state machine
  always @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      m1_valid_reg <= 1'b0;
      m1_acc_reg <= 1'b0;
      m1_prod_reg <= 64'h0000000000000000;
      o_result_high <= 32'h00000000;
      o_result_low <= 32'h00000000;
      o_mdu_busy <= 1'b0;
      div_state_reg <= DIV_IDLE;
      div_cyc_reg <= 6'h00;
      div_steps_reg <= 6'h00;
      div_rem_reg <= 32'h00000000;
      div_q_reg <= 32'h00000000;
      div_dvs_reg <= 32'h00000000;
      div_qneg_reg <= 1'b0;
      div_rneg_reg <= 1'b0;
    end
    else if (i_ce)
    begin
      m1_valid_reg <= mul_go;
      m1_acc_reg <= i_op == `CXD_OP_FUSED_MUL_ADD;
      m1_prod_reg <= mul_full;
      if (m1_valid_reg)
        {o_result_high, o_result_low} <= m1_acc_reg ?
          {o_result_high, o_result_low} + m1_prod_reg : m1_prod_reg;
      case (div_state_reg)
        DIV_IDLE:
        begin
          if (issue && is_div)
          begin
            div_state_reg <= DIV_RUN;
            div_cyc_reg <= (div_n > `CXD_DIV_MIN_CYC) ? div_n : `CXD_DIV_MIN_CYC;
            div_steps_reg <= div_n;
            div_rem_reg <= 32'h00000000;
            div_q_reg <= div_absa << div_lz;
            div_dvs_reg <= div_sb ? ~rt_val + 32'h00000001 : rt_val;
            div_qneg_reg <= div_sa ^ div_sb;
            div_rneg_reg <= div_sa;
          end
        end
        DIV_RUN:
        begin
          div_rem_reg <= div_rem_n;
          div_q_reg <= div_q_n;
          div_steps_reg <= div_do ? div_steps_reg - 6'h01 : div_steps_reg;
          div_cyc_reg <= div_cyc_reg - 6'h01;
          if (div_done)
          begin
            div_state_reg <= DIV_IDLE;
            o_result_high <= div_rneg_reg ? ~div_rem_n + 32'h00000001 : div_rem_n;
            o_result_low <= div_qneg_reg ? ~div_q_n + 32'h00000001 : div_q_n;
          end
        end
        default: div_state_reg <= DIV_IDLE;
      endcase
      o_mdu_busy <= mul_go | (issue & is_div & (div_state_reg == DIV_IDLE)) |
                    ((div_state_reg == DIV_RUN) & ~div_done);
    end
  end

  // Float pipeline: in-order results, loads and stores at any cycle
  always @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      fp_phase_reg <= 1'b0;
      o_fp_ready <= FP_HALF_RATE == 0;
      fwb_valid_reg <= 1'b0;
      fwb_idx_reg <= 5'h00;
      o_fp_result_valid <= 1'b0;
      o_fp_result <= 64'h0000000000000000;
      o_fp_tiny <= 1'b0;
      o_fp_unimpl <= 1'b0;
      o_fp_store_valid <= 1'b0;
      o_fp_store_data <= 64'h0000000000000000;
    end
    else if (i_ce)
    begin
      fp_phase_reg <= ~fp_phase_reg;
      o_fp_ready <= (FP_HALF_RATE == 0) | ~fp_phase_reg;
      o_fp_result_valid <= fp_issue;
      o_fp_tiny <= 1'b0;
      o_fp_unimpl <= 1'b0;
      if (fp_en)
      begin
        if (fwb_valid_reg)
          fregs[fwb_idx_reg] <= o_fp_result;
        fwb_valid_reg <= fp_issue;
      end
      // A newer load supersedes a pending result to the same register
      if (i_fp_load_valid)
      begin
        fregs[i_fp_load_idx] <= i_fp_load_data;
        if (fwb_idx_reg == i_fp_load_idx && !fp_issue)
          fwb_valid_reg <= 1'b0;
      end
      if (fp_issue)
      begin
        fwb_idx_reg <= i_fd;
        case (i_fp_op)
          `CXD_FOP_MOVD: o_fp_result <= fa;
          `CXD_FOP_NEGD: o_fp_result <= {~fa[63], fa[62:0]};
          `CXD_FOP_ABSD: o_fp_result <= {1'b0, fa[62:0]};
          default:       o_fp_result <= {32'h00000000, fp_res[31:0]};
        endcase
        o_fp_tiny <= fp_res[32] & i_fp_flush & (i_fp_op < `CXD_FOP_MOVD);
        o_fp_unimpl <= fp_res[32] & ~i_fp_flush & (i_fp_op < `CXD_FOP_MOVD);
      end
      o_fp_store_valid <= i_fp_store_req;
      if (i_fp_store_req)
        o_fp_store_data <= fst;
    end
  end

endmodule

/* test/cxd_exec_asserts.sv */
// Port checks for the execution datapath
`timescale 1ns/10ps
`include "cxd_consts.vh"
module cxd_exec_asserts
(
  input wire       i_clk,
  input wire       i_sys_rst,
  input wire       i_ce,
  input wire       i_issue_valid,
  input wire [4:0] i_op,
  input wire [4:0] i_rd,
  input wire       i_pred_taken,
  input wire       i_fp_valid,
  input wire       i_fp_flush,
  input wire       o_issue_ready,
  input wire       o_result_valid,
  input wire       o_mem_re,
  input wire       o_branch_valid,
  input wire       o_branch_taken,
  input wire       o_mispredict,
  input wire       o_mdu_busy,
  input wire       o_fp_ready,
  input wire       o_fp_result_valid,
  input wire       o_fp_tiny
);
  // Integer instruction accepted this edge
  wire take = i_ce & i_issue_valid & o_issue_ready;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  a_alu_one_cycle: assert property (take && i_op <= `CXD_OP_CLO && i_rd != 5'h00
    |=> o_result_valid) else $error("alu result late");
  a_load_holds_issue: assert property (take && i_op == `CXD_OP_LOAD
    |=> o_mem_re && !o_issue_ready) else $error("load not started");
  a_branch_verify: assert property (take && (i_op == `CXD_OP_BEQ || i_op == `CXD_OP_BNE)
    |=> o_branch_valid && o_mispredict == (o_branch_taken != $past(i_pred_taken)))
    else $error("branch check wrong");
  a_mul_each_cycle: assert property (take && (i_op == `CXD_OP_MULT || i_op == `CXD_OP_FUSED_MUL_ADD)
    |=> o_issue_ready) else $error("multiply blocked issue");
  a_div_six_busy: assert property (take && (i_op == `CXD_OP_DIV || i_op == `CXD_OP_DIVU)
    |=> o_mdu_busy [*6]) else $error("divide too short");
  a_hilo_read_stall: assert property (take && o_mdu_busy && i_op >= `CXD_OP_MFHI
    |=> !o_issue_ready) else $error("high/low read not held");
  a_fp_one_cycle: assert property (i_ce && i_fp_valid && o_fp_ready
    |=> o_fp_result_valid) else $error("float result late");
  a_flush_flag: assert property (o_fp_tiny |-> $past(i_fp_flush))
    else $error("tiny flag without flush");
endmodule
bind cxd_exec_datapath cxd_exec_asserts chk_u (.*);

/* test/cxd_exec_datapath_tb.sv */
// Self-checking bench of the execution datapath
`timescale 1ns/10ps
`include "cxd_consts.vh"
module cxd_exec_datapath_tb;
  reg         i_clk = 1'b0, i_sys_rst = 1'b1, i_issue_valid = 1'b0, i_use_shadow = 1'b0;
  reg         i_use_imm = 1'b0, i_pred_taken = 1'b0, i_fp_valid = 1'b0, i_fp_flush = 1'b0;
  reg         i_fp_load_valid = 1'b0;
  reg  [3:0]  i_thread = 4'h0;
  reg  [4:0]  i_op = 5'h00, i_rs = 5'h00, i_rt = 5'h00, i_rd = 5'h00, i_fp_load_idx = 5'h00;
  reg  [4:0]  i_fs = 5'h00, i_ft = 5'h00, i_fd = 5'h00;
  reg  [2:0]  i_fp_op = 3'h0;
  reg  [15:0] i_imm = 16'h0000;
  reg  [63:0] i_fp_load_data = 64'h0;
  wire        i_load_valid, o_result_valid, o_mem_re, o_mem_we, o_branch_valid, o_fp_tiny;
  wire        o_branch_taken, o_mispredict, o_mdu_busy, o_fp_result_valid;
  wire [3:0]  o_mem_be;
  wire [31:0] i_load_data, o_result, o_mem_addr, o_mem_wdata, o_result_high, o_result_low;
  wire [63:0] o_fp_result;
  integer     num_errors = 0, num_checks = 0, cyc = 0, n;
  always #50 i_clk = ~i_clk;
  // Cycle ceiling against hangs
  always @(posedge i_clk) begin cyc = cyc + 1; if (cyc == 2000) begin
    num_errors = num_errors + 1; report_and_stop; end end
  cxd_exec_datapath #(.FP_HALF_RATE(0)) dut_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_ce(1'b1), .i_issue_valid(i_issue_valid), .i_thread(i_thread), .i_use_shadow(i_use_shadow),
    .i_op(i_op), .i_rs(i_rs), .i_rt(i_rt), .i_rd(i_rd), .i_imm(i_imm), .i_use_imm(i_use_imm),
    .i_mem_size(`CXD_SZ_BYTE), .i_load_signed(1'b1), .i_pred_taken(i_pred_taken),
    .i_load_valid(i_load_valid), .i_load_data(i_load_data), .i_fp_valid(i_fp_valid),
    .i_fp_op(i_fp_op), .i_fs(i_fs), .i_ft(i_ft), .i_fd(i_fd), .i_fp_flush(i_fp_flush),
    .i_fp_load_valid(i_fp_load_valid), .i_fp_load_idx(i_fp_load_idx), .o_issue_ready(),
    .i_fp_load_data(i_fp_load_data), .i_fp_store_req(1'b0), .i_fp_store_idx(5'h00),
    .o_result_valid(o_result_valid), .o_result(o_result), .o_mem_re(o_mem_re),
    .o_mem_we(o_mem_we), .o_mem_addr(o_mem_addr), .o_mem_be(o_mem_be), .o_fp_ready(),
    .o_mem_wdata(o_mem_wdata), .o_branch_valid(o_branch_valid), .o_mdu_busy(o_mdu_busy),
    .o_branch_taken(o_branch_taken), .o_mispredict(o_mispredict), .o_fp_tiny(o_fp_tiny),
    .o_result_high(o_result_high), .o_result_low(o_result_low), .o_fp_unimpl(),
    .o_fp_result_valid(o_fp_result_valid), .o_fp_result(o_fp_result), .o_fp_store_valid(),
    .o_fp_store_data());
  cxd_mem_model mem_u (.i_clk(i_clk), .i_re(o_mem_re), .i_addr(o_mem_addr),
    .o_valid(i_load_valid), .o_data(i_load_data));
  // Helpers
  task chk(input [63:0] nm, input [71:0] ex, got); begin num_checks = num_checks + 1;
    if (got !== ex) begin num_errors = num_errors + 1;
      $display("unexpected %0s exp %h got %h", nm, ex, got); end end endtask
  task iss(input [4:0] op, rd, rs, rt, input [15:0] imm, input ui); begin
    {i_op, i_rd, i_rs, i_rt, i_imm, i_use_imm, i_issue_valid} = {op, rd, rs, rt, imm, ui, 1'b1};
    @(posedge i_clk) #1; end endtask
  task alu(input [4:0] op, rd, rs, rt, input [15:0] imm, input ui, input [31:0] ex); begin
    iss(op, rd, rs, rt, imm, ui); chk("alu", {40'h1, ex}, {39'h0, o_result_valid, o_result});
  end endtask
  task wait_res; begin i_issue_valid = 1'b0;
    for (n = 0; n < 9 && o_result_valid !== 1'b1; n = n + 1) @(posedge i_clk) #1; end endtask
  task fld(input [4:0] idx, input [63:0] d); begin
    {i_fp_load_valid, i_fp_load_idx, i_fp_load_data} = {1'b1, idx, d}; @(posedge i_clk) #1;
  end endtask
  task fop(input [2:0] op, input [4:0] fd, fs, ft, input [63:0] ex); begin
    {i_fp_op, i_fd, i_fs, i_ft, i_fp_valid} = {op, fd, fs, ft, 1'b1}; @(posedge i_clk) #1;
    chk("fp", {8'h1, ex}, {7'h0, o_fp_result_valid, o_fp_result}); end endtask
  task report_and_stop; begin $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish; end endtask
  // Back-to-back ALU chain through the bypass, count leading bits
  task t_alu; begin
    alu(`CXD_OP_ADD, 5'h1, 5'h0, 5'h0, 16'h7, 1'b1, 32'h7);
    alu(`CXD_OP_ADD, 5'h2, 5'h1, 5'h1, 16'h0, 1'b0, 32'hE);
    alu(`CXD_OP_SUB, 5'h3, 5'h2, 5'h1, 16'h0, 1'b0, 32'h7);
    alu(`CXD_OP_SLL, 5'h4, 5'h1, 5'h1, 16'h4, 1'b0, 32'h70);
    alu(`CXD_OP_NOR, 5'h5, 5'h0, 5'h0, 16'h0, 1'b0, 32'hFFFFFFFF);
    alu(`CXD_OP_CLO, 5'h6, 5'h5, 5'h5, 16'h0, 1'b0, 32'h20);
    alu(`CXD_OP_CLZ, 5'h6, 5'h1, 5'h1, 16'h0, 1'b0, 32'h1D); end endtask
  // Per-thread and shadow copies of one register
  task t_ctx; begin i_thread = 4'h1; alu(`CXD_OP_ADD, 5'h1, 5'h0, 5'h0, 16'h9, 1'b1, 32'h9);
    i_use_shadow = 1'b1; alu(`CXD_OP_ADD, 5'h1, 5'h0, 5'h0, 16'h55, 1'b1, 32'h55);
    {i_thread, i_use_shadow} = 5'h00; alu(`CXD_OP_ADD, 5'h7, 5'h1, 5'h0, 16'h0, 1'b0, 32'h7);
    i_use_shadow = 1'b1; alu(`CXD_OP_ADD, 5'h7, 5'h1, 5'h0, 16'h0, 1'b0, 32'h55);
    i_use_shadow = 1'b0; end endtask
  // Byte store lane, signed byte load
  task t_mem; begin iss(`CXD_OP_STORE, 5'h0, 5'h0, 5'h1, 16'h0101, 1'b0);
    chk("store", {4'h1, 4'h2, 32'h101, 32'h700}, {3'h0, o_mem_we, o_mem_be, o_mem_addr, o_mem_wdata});
    iss(`CXD_OP_LOAD, 5'h8, 5'h0, 5'h0, 16'h0083, 1'b0);
    chk("load", {40'h1, 32'h83}, {39'h0, o_mem_re, o_mem_addr}); wait_res;
    chk("align", {40'h1, 32'hFFFFFF83}, {39'h0, o_result_valid, o_result}); end endtask
  // Branch outcome against prediction
  task t_br; begin iss(`CXD_OP_BEQ, 5'h0, 5'h1, 5'h1, 16'h0, 1'b0);
    chk("branch", 72'h7, {69'h0, o_branch_valid, o_branch_taken, o_mispredict});
    iss(`CXD_OP_BNE, 5'h0, 5'h1, 5'h1, 16'h0, 1'b0); i_pred_taken = 1'b1;
    chk("branch", 72'h4, {69'h0, o_branch_valid, o_branch_taken, o_mispredict});
    iss(`CXD_OP_BEQ, 5'h0, 5'h1, 5'h1, 16'h0, 1'b0); i_pred_taken = 1'b0;
    chk("branch", 72'h6, {69'h0, o_branch_valid, o_branch_taken, o_mispredict}); end endtask
  // Multiply-accumulate back to back, held low read, shortest divide
  task t_mdu; begin iss(`CXD_OP_MULT, 5'h0, 5'h1, 5'h2, 16'h0, 1'b0);
    iss(`CXD_OP_FUSED_MUL_ADD, 5'h0, 5'h1, 5'h1, 16'h0, 1'b0);
    iss(`CXD_OP_MFLO, 5'h9, 5'h0, 5'h0, 16'h0, 1'b0); wait_res;
    chk("mflo", {40'h1, 32'h93}, {39'h0, o_result_valid, o_result});
    iss(`CXD_OP_DIVU, 5'h0, 5'h2, 5'h1, 16'h0, 1'b0); i_issue_valid = 1'b0;
    for (n = 0; n < 40 && o_mdu_busy === 1'b1; n = n + 1) @(posedge i_clk) #1;
    chk("div", {8'h6, 32'h0, 32'h2}, {n[7:0], o_result_high, o_result_low}); end endtask
  // Float chain with forwarding, fused op, flushed tiny result
  task t_fp; begin fld(5'h2, 64'h3F800000); fld(5'h3, 64'h40000000); fld(5'h6, 64'h00800000);
    fld(5'h7, 64'h3F000000); i_fp_load_valid = 1'b0;
    fop(`CXD_FOP_MUL, 5'h1, 5'h2, 5'h3, 64'h40000000);
    fop(`CXD_FOP_ADD, 5'h4, 5'h1, 5'h2, 64'h40400000);
    fop(`CXD_FOP_FUSED_MUL_ADD, 5'h4, 5'h2, 5'h3, 64'h40A00000); i_fp_flush = 1'b1;
    fop(`CXD_FOP_MUL, 5'h8, 5'h6, 5'h7, 64'h0); i_fp_valid = 1'b0;
    chk("tiny", 72'h1, {71'h0, o_fp_tiny}); end endtask
  // Reset, then every scenario in turn
  initial
  begin
    repeat (8) @(posedge i_clk);
    #1 i_sys_rst = 1'b0;
    t_alu; $display("t_alu done"); t_ctx; $display("t_ctx done"); t_mem; $display("t_mem done");
    t_br; $display("t_br done"); t_mdu; $display("t_mdu done"); t_fp; $display("t_fp done");
    report_and_stop;
  end
endmodule

/* test/cxd_mem_model.sv */
// Data memory stand-in answering loads three cycles after the read request
`timescale 1ns/10ps
module cxd_mem_model
(
  input  wire        i_clk,
  input  wire        i_re,
  input  wire [31:0] i_addr,
  output reg         o_valid = 1'b0,
  output reg  [31:0] o_data = 32'h0
);
  reg [1:0] cnt_reg = 2'h0;
  // Top byte mirrors the address; idle data churns every cycle
  always @(posedge i_clk)
  begin
    cnt_reg <= i_re ? 2'h2 : cnt_reg - {1'b0, cnt_reg != 2'h0};
    o_valid <= #1 cnt_reg == 2'h1;
    o_data  <= #1 (cnt_reg == 2'h1) ? {i_addr[7:0], 24'h0000F0} : ~o_data;
  end
endmodule
